// file: rtl/dcm_pkg.sv
// Package for the drive command and monitor register bank
package dcm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [7:0] OFS_RUN_CMD    = 8'h00;
	localparam logic [7:0] OFS_FREQ_CMD   = 8'h01;
	localparam logic [7:0] OFS_DRV_STAT   = 8'h02;
	localparam logic [7:0] OFS_OUT_FREQ   = 8'h03;
	localparam logic [7:0] OFS_FIO_SEL    = 8'h04;
	localparam logic [7:0] OFS_FIO_VAL    = 8'h05;
	localparam logic [7:0] OFS_FIO_EN     = 8'h06;
	localparam logic [7:0] OFS_MAX_SCAN   = 8'h08;
	localparam logic [7:0] OFS_MIN_SCAN   = 8'h09;
	localparam logic [7:0] OFS_CUR_SCAN   = 8'h0A;
	localparam logic [7:0] OFS_CLK_YM     = 8'h0C;
	localparam logic [7:0] OFS_CLK_DH     = 8'h0D;
	localparam logic [7:0] OFS_CLK_MS     = 8'h0E;
	localparam logic [7:0] OFS_CLK_CW     = 8'h0F;
	localparam logic [7:0] OFS_FAULT_CODE = 8'h10;
	localparam logic [7:0] OFS_ERR_STEP   = 8'h11;
	localparam logic [7:0] OFS_MAP0       = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h21;
	localparam logic [7:0] OFS_IRQ_CLR    = 8'h22;
	localparam logic [7:0] OFS_HIST_PTR   = 8'h30;
	localparam logic [7:0] OFS_HIST_BASE  = 8'h31;
	localparam logic [7:0] OFS_HIST_LAST  = 8'h70;

	localparam int MAP_NUM   = 5;
	localparam int HIST_RECS = 16;
	localparam int HIST_WORDS = 64;

	// Drive common addresses that take over the fixed words
	localparam logic [15:0] FREQ_REF_ADDR = 16'h0380;
	localparam logic [15:0] OPER_REF_ADDR = 16'h0382;

	// Run command bit positions
	localparam int RUN_BIT   = 0;
	localparam int FWD_BIT   = 1;
	localparam int FRST_BIT  = 2;
	localparam int COAST_BIT = 3;

	// Interrupt status bits
	localparam int IRQ_STOP  = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_ERR   = 2;
	localparam int IRQ_W     = 3;

	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] MIN_SCAN_RESET = 16'hFFFF;

	typedef struct packed {
		logic [15:0] freq_ref;
		logic        run;
		logic        forward;
		logic        fault_reset;
		logic        coast_stop;
		logic        freq_valid;
		logic        oper_valid;
	} dcm_cmd_type;

	typedef struct packed {
		logic [15:0] status;
		logic [15:0] out_freq;
	} dcm_mon_type;

	typedef struct packed {
		logic [15:0] year_month;
		logic [15:0] day_hour;
		logic [15:0] min_sec;
		logic [15:0] cent_wday;
	} dcm_rtc_type;
endpackage

// file: rtl/dcm_hist_mem.sv
// Stop history word memory with registered read data
`timescale 1ns/1ns
module dcm_hist_mem (
	input  wire logic        clock,
	input  wire logic        we,
	input  wire logic [5:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [5:0]  raddr,
	output logic      [15:0] rdata
);
	logic [15:0] mem [0:63];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// file: rtl/dcm_regs.sv
// Drive command and monitor register bank
// Functional notes
// - Frequency command word, 0.01 Hz units, forwarded to drive as reference.
// - Run word bit0 selects stop/run, bit1 selects reverse/forward.
// - Bit2 rise pulses fault reset; bit3 rise coasts, fall releases.
// - Mapping param holding 0380h disables frequency word; zero restores it.
// - Mapping param holding 0382h disables run word; zero restores it.
// - Fixed words work without any mapping parameter configured.
// - Status word shows present drive state taken from the drive.
// - Output frequency word shows drive output frequency.
// - Output frequency counts in 0.01 Hz.
// - Max, min and present scan time words updated every scan.
// - Four clock words, valid only with clock module fitted.
// - User fault instruction stores its error code in a word.
// - Error step is recorded in its own word.
// - Forced I/O enable applies select/value pair to I/O word.
// - Each stop taken with clock module fitted while the logger is idle logs four words; pointer tracks the next entry.
// - Sixteen records kept; seventeenth overwrites the oldest.
`timescale 1ns/1ns
module dcm_regs
	import dcm_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     sys_rst,
	input  wire logic [dcm_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [15:0]              bus_wdata,
	input  wire logic                     bus_wr,
	input  wire logic                     bus_rd,
	output logic      [15:0]              bus_rdata,
	input  wire logic                     scan_end,
	input  wire logic [15:0]              scan_time,
	input  wire dcm_pkg::dcm_mon_type     drv_mon,
	input  wire logic                     rtc_fitted,
	input  wire dcm_pkg::dcm_rtc_type     rtc_time,
	input  wire logic                     fault_exec,
	input  wire logic [15:0]              fault_code,
	input  wire logic                     err_event,
	input  wire logic [15:0]              err_step,
	input  wire logic                     stop_event,
	input  wire logic [15:0]              stop_code,
	input  wire logic [15:0]              io_in,
	output dcm_pkg::dcm_cmd_type          drv_cmd,
	output logic      [15:0]              io_out,
	output logic                          irq
);
	import dcm_pkg::*;

	typedef enum logic [2:0] {LOG_IDLE, LOG_YM, LOG_DH, LOG_MS, LOG_CODE} dcm_log_type;

	function automatic logic map_hit(input logic [5*16-1:0] m, input logic [15:0] a);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < MAP_NUM; i++) begin
			if (m[i*16 +: 16] == a) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	logic [15:0] run_cmd_r, freq_cmd_r, fio_sel_r, fio_val_r;
	logic        fio_en_r;
	logic [15:0] max_scan_r, min_scan_r, cur_scan_r;
	logic [15:0] fault_code_r, err_step_r;
	logic [15:0] stat_r, ofreq_r;
	logic [5*16-1:0] map_r;
	logic [IRQ_W-1:0] irq_stat_r, irq_en_r;
	logic [3:0]  hist_ptr_r;
	logic        hist_full_r;
	dcm_log_type log_state_r;
	logic [15:0] log_code_r;
	logic [15:0] rd_hold_r;
	logic        rd_mem_r;
	dcm_cmd_type drv_cmd_r;
	logic [15:0] io_out_r;
	logic        irq_r;
	logic        coast_prev_r, frst_prev_r;

	// Address decode
	wire wr_run   = bus_wr && bus_addr == OFS_RUN_CMD;
	wire wr_freq  = bus_wr && bus_addr == OFS_FREQ_CMD;
	wire wr_fsel  = bus_wr && bus_addr == OFS_FIO_SEL;
	wire wr_fval  = bus_wr && bus_addr == OFS_FIO_VAL;
	wire wr_fen   = bus_wr && bus_addr == OFS_FIO_EN;
	wire wr_ien   = bus_wr && bus_addr == OFS_IRQ_EN;
	wire wr_iclr  = bus_wr && bus_addr == OFS_IRQ_CLR;
	wire map_sel  = bus_addr >= OFS_MAP0 && bus_addr < OFS_MAP0 + 8'(MAP_NUM);
	wire [2:0] map_idx = 3'(bus_addr - OFS_MAP0);
	wire hist_sel = bus_addr >= OFS_HIST_BASE && bus_addr <= OFS_HIST_LAST;
	wire [5:0] hist_raddr = 6'(bus_addr - OFS_HIST_BASE);

	// Takeover by mapping parameters; all-zero mapping leaves fixed words live
	wire freq_taken = map_hit(map_r, FREQ_REF_ADDR);
	wire oper_taken = map_hit(map_r, OPER_REF_ADDR);

	// Stop logging engine writes four words per record
	logic        mem_we;
	logic [5:0]  mem_waddr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	wire [1:0] log_word = log_state_r == LOG_YM ? 2'h0 :
		log_state_r == LOG_DH ? 2'h1 : log_state_r == LOG_MS ? 2'h2 : 2'h3;
	assign mem_we    = log_state_r != LOG_IDLE;
	assign mem_waddr = {hist_ptr_r, log_word};
	assign mem_wdata = log_state_r == LOG_YM ? rtc_time.year_month :
		log_state_r == LOG_DH ? rtc_time.day_hour :
		log_state_r == LOG_MS ? rtc_time.min_sec : log_code_r;

	dcm_hist_mem u_mem (
		.clock (clock),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (hist_raddr),
		.rdata (mem_rdata)
	);

	// Clock words read zero when no clock module is fitted
	dcm_rtc_type rtc_vis;
	assign rtc_vis = rtc_fitted ? rtc_time : {4{RESET_WORD}};

	// Read mux
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = RESET_WORD;
		if (bus_addr == OFS_RUN_CMD) rd_mux = run_cmd_r;
		else if (bus_addr == OFS_FREQ_CMD) rd_mux = freq_cmd_r;
		else if (bus_addr == OFS_DRV_STAT) rd_mux = stat_r;
		else if (bus_addr == OFS_OUT_FREQ) rd_mux = ofreq_r;
		else if (bus_addr == OFS_FIO_SEL) rd_mux = fio_sel_r;
		else if (bus_addr == OFS_FIO_VAL) rd_mux = fio_val_r;
		else if (bus_addr == OFS_FIO_EN) rd_mux = {15'h0000, fio_en_r};
		else if (bus_addr == OFS_MAX_SCAN) rd_mux = max_scan_r;
		else if (bus_addr == OFS_MIN_SCAN) rd_mux = min_scan_r;
		else if (bus_addr == OFS_CUR_SCAN) rd_mux = cur_scan_r;
		else if (bus_addr == OFS_CLK_YM) rd_mux = rtc_vis.year_month;
		else if (bus_addr == OFS_CLK_DH) rd_mux = rtc_vis.day_hour;
		else if (bus_addr == OFS_CLK_MS) rd_mux = rtc_vis.min_sec;
		else if (bus_addr == OFS_CLK_CW) rd_mux = rtc_vis.cent_wday;
		else if (bus_addr == OFS_FAULT_CODE) rd_mux = fault_code_r;
		else if (bus_addr == OFS_ERR_STEP) rd_mux = err_step_r;
		else if (map_sel) rd_mux = map_r[map_idx*16 +: 16];
		else if (bus_addr == OFS_IRQ_STAT) rd_mux = {13'h0000, irq_stat_r};
		else if (bus_addr == OFS_IRQ_EN) rd_mux = {13'h0000, irq_en_r};
		else if (bus_addr == OFS_HIST_PTR) rd_mux = {11'h000, hist_full_r, hist_ptr_r};
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_hold_r <= RESET_WORD;
			rd_mem_r  <= 1'b0;
		end else begin
			rd_hold_r <= bus_rd ? rd_mux : RESET_WORD;
			rd_mem_r  <= bus_rd && hist_sel;
		end
	end
	assign bus_rdata = rd_mem_r ? mem_rdata : rd_hold_r;

	// Software-written words
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			run_cmd_r  <= RESET_WORD;
			freq_cmd_r <= RESET_WORD;
			fio_sel_r  <= RESET_WORD;
			fio_val_r  <= RESET_WORD;
			fio_en_r   <= 1'b0;
			irq_en_r   <= '0;
			map_r      <= '0;
		end else begin
			if (wr_run) run_cmd_r <= bus_wdata;
			if (wr_freq) freq_cmd_r <= bus_wdata;
			if (wr_fsel) fio_sel_r <= bus_wdata;
			if (wr_fval) fio_val_r <= bus_wdata;
			if (wr_fen) fio_en_r <= bus_wdata[0];
			if (wr_ien) irq_en_r <= bus_wdata[IRQ_W-1:0];
			if (bus_wr && map_sel) map_r[map_idx*16 +: 16] <= bus_wdata;
		end
	end

	// Per-scan transfer to the drive and monitor refresh
	wire coast_now = run_cmd_r[COAST_BIT];
	wire frst_now  = run_cmd_r[FRST_BIT];
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			drv_cmd_r    <= '0;
			stat_r       <= RESET_WORD;
			ofreq_r      <= RESET_WORD;
			coast_prev_r <= 1'b0;
			frst_prev_r  <= 1'b0;
		end else begin
			drv_cmd_r.fault_reset <= 1'b0;
			if (scan_end) begin
				stat_r  <= drv_mon.status;
				ofreq_r <= drv_mon.out_freq;
				drv_cmd_r.freq_valid <= !freq_taken;
				drv_cmd_r.oper_valid <= !oper_taken;
				if (!freq_taken) drv_cmd_r.freq_ref <= freq_cmd_r;
				if (!oper_taken) begin
					drv_cmd_r.run     <= run_cmd_r[RUN_BIT];
					drv_cmd_r.forward <= run_cmd_r[FWD_BIT];
					drv_cmd_r.fault_reset <= frst_now && !frst_prev_r;
					// Level follows bit: rise coasts, fall releases
					if (coast_now && !coast_prev_r) drv_cmd_r.coast_stop <= 1'b1;
					else if (!coast_now && coast_prev_r) drv_cmd_r.coast_stop <= 1'b0;
					coast_prev_r <= coast_now;
					frst_prev_r  <= frst_now;
				end
			end
		end
	end
	assign drv_cmd = drv_cmd_r;

	// Scan statistics, fault code, error step
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			max_scan_r   <= RESET_WORD;
			min_scan_r   <= MIN_SCAN_RESET;
			cur_scan_r   <= RESET_WORD;
			fault_code_r <= RESET_WORD;
			err_step_r   <= RESET_WORD;
		end else begin
			if (scan_end) begin
				cur_scan_r <= scan_time;
				if (scan_time > max_scan_r) max_scan_r <= scan_time;
				if (scan_time < min_scan_r) min_scan_r <= scan_time;
			end
			if (fault_exec) fault_code_r <= fault_code;
			if (err_event) err_step_r <= err_step;
		end
	end

	// Forced I/O: forced bits take the value word, others pass through
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			io_out_r <= RESET_WORD;
		end else begin
			io_out_r <= fio_en_r ? ((io_in & ~fio_sel_r) | (fio_val_r & fio_sel_r)) : io_in;
		end
	end
	assign io_out = io_out_r;

	// Stop history ring; a stop during logging is dropped
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			log_state_r <= LOG_IDLE;
			log_code_r  <= RESET_WORD;
			hist_ptr_r  <= 4'h0;
			hist_full_r <= 1'b0;
		end else begin
			case (log_state_r)
				LOG_IDLE: begin
					if (stop_event && rtc_fitted) begin
						log_code_r  <= stop_code;
						log_state_r <= LOG_YM;
					end
				end
				LOG_YM: log_state_r <= LOG_DH;
				LOG_DH: log_state_r <= LOG_MS;
				LOG_MS: log_state_r <= LOG_CODE;
				LOG_CODE: begin
					log_state_r <= LOG_IDLE;
					hist_ptr_r  <= hist_ptr_r + 4'h1;
					if (hist_ptr_r == 4'hF) hist_full_r <= 1'b1;
				end
				default: log_state_r <= LOG_IDLE;
			endcase
		end
	end

	// Interrupts: set wins over clear
	wire [IRQ_W-1:0] irq_set = {err_event, fault_exec, stop_event};
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_r <= '0;
			irq_r      <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~(wr_iclr ? bus_wdata[IRQ_W-1:0] : '0)) | irq_set;
			irq_r      <= |(irq_stat_r & irq_en_r);
		end
	end
	assign irq = irq_r;

	fresh_a: assert property (@(posedge clock) disable iff (sys_rst)
		scan_end |=> ofreq_r == $past(drv_mon.out_freq))
		else $error("output freq not refreshed");
	freq_fwd_a: assert property (@(posedge clock) disable iff (sys_rst)
		scan_end && !freq_taken |=> drv_cmd.freq_ref == $past(freq_cmd_r))
		else $error("freq not sent");
	freq_block_a: assert property (@(posedge clock) disable iff (sys_rst)
		freq_taken |=> $stable(drv_cmd.freq_ref))
		else $error("freq sent while mapped");
	run_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
		scan_end && !oper_taken |=> drv_cmd.run == $past(run_cmd_r[0]) &&
		drv_cmd.forward == $past(run_cmd_r[1]))
		else $error("run bits wrong");
	frst_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
		drv_cmd.fault_reset |=> !drv_cmd.fault_reset)
		else $error("fault reset not a pulse");
	oper_block_a: assert property (@(posedge clock) disable iff (sys_rst)
		oper_taken |=> $stable(drv_cmd.run))
		else $error("run sent while mapped");
	scan_max_a: assert property (@(posedge clock) disable iff (sys_rst)
		scan_end |=> max_scan_r >= $past(scan_time))
		else $error("max scan wrong");
	scan_min_a: assert property (@(posedge clock) disable iff (sys_rst)
		scan_end |=> min_scan_r <= $past(scan_time))
		else $error("min scan wrong");
	fault_code_a: assert property (@(posedge clock) disable iff (sys_rst)
		fault_exec |=> fault_code_r == $past(fault_code))
		else $error("fault code lost");
	err_step_a: assert property (@(posedge clock) disable iff (sys_rst)
		err_event |=> err_step_r == $past(err_step))
		else $error("error step lost");
	// Only forced bits are checked; the rest follow the raw word
	forced_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
		fio_en_r |=> ((io_out ^ $past(fio_val_r)) & $past(fio_sel_r)) == 16'h0000)
		else $error("forced bits wrong");
	irq_level_a: assert property (@(posedge clock) disable iff (sys_rst)
		|(irq_stat_r & irq_en_r) |=> irq)
		else $error("irq not raised");
	rd_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
		!bus_rd |=> bus_rdata == 16'h0000)
		else $error("read data not cleared");
	sequence log_walk_s;
		log_state_r == LOG_YM ##1 log_state_r == LOG_DH ##1 log_state_r == LOG_MS
		##1 log_state_r == LOG_CODE;
	endsequence
	log_seq_a: assert property (@(posedge clock) disable iff (sys_rst)
		log_state_r == LOG_IDLE && stop_event && rtc_fitted |=> log_walk_s)
		else $error("log walk");
	ptr_wrap_a: assert property (@(posedge clock) disable iff (sys_rst)
		log_state_r == LOG_CODE && hist_ptr_r == 4'hF |=> hist_ptr_r == 4'h0)
		else $error("no wrap");
endmodule

// file: tb/dcm_drive_model.sv
// Behavioural motor drive answering the command struct with monitor data
`timescale 1ns/1ns
module dcm_drive_model
	import dcm_pkg::*;
(
	input  wire logic                 clock,
	input  wire dcm_pkg::dcm_cmd_type drv_cmd,
	output dcm_pkg::dcm_mon_type      drv_mon
);
	wire logic running = drv_cmd.run & ~drv_cmd.coast_stop;
	wire logic [3:0] dir_code = drv_cmd.forward ? 4'h1 : 4'h2;

	// No ramp modelled: constant speed as soon as running, so expectations stay exact
	always_ff @(posedge clock) begin
		drv_mon.status   <= running ? {8'h00, 4'h3, dir_code} : 16'h0000;
		drv_mon.out_freq <= running ? drv_cmd.freq_ref : 16'h0000;
	end
endmodule

// file: tb/drive_command_monitor_regs_tb_top.sv
// Self-checking bench for the drive command and monitor register bank
`timescale 1ns/1ns
module drive_command_monitor_regs_tb_top;
	import dcm_pkg::*;
	logic        clock, sys_rst, bus_wr, bus_rd, scan_end, rtc_fitted, irq;
	logic        fault_exec, err_event, stop_event;
	logic [7:0]  bus_addr;
	logic [15:0] bus_wdata, bus_rdata, scan_time, fault_code, err_step;
	logic [15:0] stop_code, io_in, io_out;
	dcm_mon_type drv_mon;
	dcm_rtc_type rtc_time;
	dcm_cmd_type drv_cmd;
	int          fails, checks_done;

	dcm_regs dcm_regs_i (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.scan_end(scan_end), .scan_time(scan_time), .drv_mon(drv_mon),
		.rtc_fitted(rtc_fitted), .rtc_time(rtc_time), .fault_exec(fault_exec),
		.fault_code(fault_code), .err_event(err_event), .err_step(err_step),
		.stop_event(stop_event), .stop_code(stop_code), .io_in(io_in),
		.drv_cmd(drv_cmd), .io_out(io_out), .irq(irq));
	dcm_drive_model dcm_drive_model_i (.clock(clock), .drv_cmd(drv_cmd), .drv_mon(drv_mon));

	task automatic stop_test;
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, exp, what);
	endtask

	task automatic scan(input logic [15:0] t);
		@(posedge clock);
		scan_end <= 1'b1;
		scan_time <= t;
		@(posedge clock);
		scan_end <= 1'b0;
		#1;
	endtask

	// Event pulse, then room for the four-cycle history write
	task automatic fire(input int k, input logic [15:0] v);
		@(posedge clock);
		case (k)
			0: begin fault_exec <= 1'b1; fault_code <= v; end
			1: begin err_event <= 1'b1; err_step <= v; end
			default: begin stop_event <= 1'b1; stop_code <= v; end
		endcase
		@(posedge clock);
		fault_exec <= 1'b0;
		err_event <= 1'b0;
		stop_event <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	task automatic t_command;
		wr(OFS_FREQ_CMD, 16'h0BB8);
		wr(OFS_RUN_CMD, 16'h0003);
		chk(drv_cmd.freq_ref, 16'h0000, "sent before scan");
		scan(16'h0040);
		chk(drv_cmd.freq_ref, 16'h0BB8, "freq ref");
		chk({14'h0, drv_cmd.run, drv_cmd.forward}, 16'h0003, "run fwd");
		chk({14'h0, drv_cmd.freq_valid, drv_cmd.oper_valid}, 16'h0003, "fixed live");
		wr(OFS_RUN_CMD, 16'h0005);
		scan(16'h0040);
		chk({15'h0, drv_cmd.fault_reset}, 16'h0001, "fault reset");
		chk({14'h0, drv_cmd.run, drv_cmd.forward}, 16'h0002, "run rev");
		@(posedge clock);
		#1 chk({15'h0, drv_cmd.fault_reset}, 16'h0000, "reset width");
		scan(16'h0040);
		chk({15'h0, drv_cmd.fault_reset}, 16'h0000, "level no reset");
		wr(OFS_RUN_CMD, 16'h0009);
		scan(16'h0040);
		chk({15'h0, drv_cmd.coast_stop}, 16'h0001, "coast set");
		wr(OFS_RUN_CMD, 16'h0001);
		scan(16'h0040);
		chk({15'h0, drv_cmd.coast_stop}, 16'h0000, "coast release");
		wr(OFS_RUN_CMD, 16'h0003);
		scan(16'h0040);
	endtask

	task automatic t_monitor;
		scan(16'h0040);
		rd_chk(OFS_DRV_STAT, 16'h0031, "status");
		rd_chk(OFS_OUT_FREQ, 16'h0BB8, "out freq");
		wr(OFS_DRV_STAT, 16'hFFFF);
		rd_chk(OFS_DRV_STAT, 16'h0031, "status read only");
		rd_chk(8'h07, 16'h0000, "unmapped");
	endtask

	task automatic t_mapping;
		wr(OFS_MAP0 + 8'h04, FREQ_REF_ADDR);
		wr(OFS_FREQ_CMD, 16'h1194);
		scan(16'h0040);
		chk(drv_cmd.freq_ref, 16'h0BB8, "freq frozen");
		chk({15'h0, drv_cmd.freq_valid}, 16'h0000, "freq valid off");
		wr(OFS_MAP0 + 8'h04, 16'h0000);
		scan(16'h0040);
		chk(drv_cmd.freq_ref, 16'h1194, "freq restored");
		wr(OFS_MAP0, OPER_REF_ADDR);
		wr(OFS_RUN_CMD, 16'h0000);
		scan(16'h0040);
		chk({15'h0, drv_cmd.run}, 16'h0001, "run frozen");
		chk({15'h0, drv_cmd.oper_valid}, 16'h0000, "oper valid off");
		wr(OFS_MAP0, 16'h0000);
		scan(16'h0040);
		chk({15'h0, drv_cmd.run}, 16'h0000, "run restored");
		chk({14'h0, drv_cmd.freq_valid, drv_cmd.oper_valid}, 16'h0003, "both live");
	endtask

	// Mid-run reset: outputs clear, statistics back to reset values
	task automatic t_reset;
		@(posedge clock);
		sys_rst <= 1'b1;
		@(posedge clock);
		#1 chk(drv_cmd.freq_ref, 16'h0000, "freq in reset");
		chk(io_out, 16'h0000, "io in reset");
		chk({15'h0, irq}, 16'h0000, "irq in reset");
		@(posedge clock);
		sys_rst <= 1'b0;
		rd_chk(OFS_MIN_SCAN, MIN_SCAN_RESET, "min scan reset");
		rd_chk(OFS_MAX_SCAN, 16'h0000, "max scan reset");
		rd_chk(OFS_HIST_PTR, 16'h0000, "pointer reset");
	endtask

	task automatic t_scan_rtc;
		scan(16'h0050);
		scan(16'h0020);
		scan(16'h0030);
		rd_chk(OFS_MAX_SCAN, 16'h0050, "max scan");
		rd_chk(OFS_MIN_SCAN, 16'h0020, "min scan");
		rd_chk(OFS_CUR_SCAN, 16'h0030, "cur scan");
		rd_chk(OFS_CLK_YM, 16'h0000, "no clock module");
		rtc_fitted <= 1'b1;
		scan(16'h0040);
		for (int i = 0; i < 4; i++) begin
			rd_chk(OFS_CLK_YM + 8'(i), rtc_time[16*(3-i) +: 16], "clock word");
		end
	endtask

	task automatic t_faults;
		wr(OFS_IRQ_EN, 16'h0002);
		fire(0, 16'h0BAD);
		fire(1, 16'h0123);
		rd_chk(OFS_FAULT_CODE, 16'h0BAD, "fault code");
		rd_chk(OFS_ERR_STEP, 16'h0123, "error step");
		rd_chk(OFS_IRQ_STAT, 16'h0006, "irq status");
		chk({15'h0, irq}, 16'h0001, "irq on");
		wr(OFS_IRQ_CLR, 16'h0002);
		rd_chk(OFS_IRQ_STAT, 16'h0004, "irq cleared");
		chk({15'h0, irq}, 16'h0000, "irq masked");
		wr(OFS_IRQ_CLR, 16'h0004);
	endtask

	task automatic t_forced;
		io_in <= 16'h00FF;
		wr(OFS_FIO_SEL, 16'h0F0F);
		wr(OFS_FIO_VAL, 16'hAAAA);
		repeat (2) @(posedge clock);
		#1 chk(io_out, 16'h00FF, "not forced");
		wr(OFS_FIO_EN, 16'h0001);
		repeat (2) @(posedge clock);
		#1 chk(io_out, 16'h0AFA, "forced");
		wr(OFS_FIO_EN, 16'h0000);
		repeat (2) @(posedge clock);
		#1 chk(io_out, 16'h00FF, "force off");
	endtask

	task automatic t_history;
		wr(OFS_IRQ_EN, 16'h0001);
		for (int i = 1; i <= 17; i++) begin
			fire(2, 16'hA000 + 16'(i));
			if (i == 1) begin
				rd_chk(OFS_HIST_PTR, 16'h0001, "first pointer");
			end
		end
		rd_chk(OFS_HIST_PTR, 16'h0011, "wrapped pointer");
		rd_chk(OFS_HIST_BASE, rtc_time.year_month, "record ym");
		rd_chk(OFS_HIST_BASE + 8'h02, rtc_time.min_sec, "record ms");
		rd_chk(OFS_HIST_BASE + 8'h03, 16'hA011, "oldest replaced");
		rd_chk(OFS_HIST_BASE + 8'h07, 16'hA002, "second kept");
		rd_chk(OFS_HIST_LAST, 16'hA010, "last record");
		chk({15'h0, irq}, 16'h0001, "stop irq");
		wr(OFS_IRQ_CLR, 16'h0001);
		repeat (2) @(posedge clock);
		#1 chk({15'h0, irq}, 16'h0000, "stop irq cleared");
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		{sys_rst, bus_wr, bus_rd, scan_end, rtc_fitted} = 5'b10000;
		{fault_exec, err_event, stop_event} = 3'b000;
		{bus_addr, bus_wdata, scan_time, fault_code} = '0;
		{err_step, stop_code, io_in} = '0;
		rtc_time = {16'h2406, 16'h1512, 16'h3045, 16'h2003};
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		t_command();
		t_monitor();
		t_mapping();
		t_scan_rtc();
		t_faults();
		t_forced();
		t_history();
		t_reset();
		stop_test();
	end

	// A hang is cut short after a bounded number of cycles
	initial begin
		for (int n = 0; n < 100000; n++) begin
			@(posedge clock);
		end
		fails++;
		$display("ERROR %0t run limit reached", $time);
		stop_test();
	end
endmodule
